/* bad_cfg.svh */
// offsets, field positions, reset values and timing counts of the boot loader
`ifndef BAD_CFG_SVH
`define BAD_CFG_SVH

// =====================================================================
// register byte offsets
`define BAD_OFF_CFG_ADDR 12'h000
`define BAD_OFF_SWITCH 12'h004
`define BAD_OFF_ACTIVE 12'h008
`define BAD_OFF_PARAM 12'h00c
`define BAD_OFF_CALL 12'h010
`define BAD_OFF_RESULT 12'h014
`define BAD_OFF_IRQ_STAT 12'h018
`define BAD_OFF_IRQ_MASK 12'h01c
`define BAD_OFF_BOOT 12'h020
`define BAD_OFF_DELAY 12'h7f0

// =====================================================================
// interrupt status bit positions
`define BAD_IRQ_CALL 0
`define BAD_IRQ_DELAY_DONE 1
`define BAD_IRQ_DELAY_REJ 2
`define BAD_IRQ_W 3

// =====================================================================
// values
`define BAD_DLY_MIN 32'h0000000a
`define BAD_DLY_MAX 32'h00000258
`define BAD_DLY_INIT 10'h00a
`define BAD_CFG_INIT 32'hc0a80a01
`define BAD_DEF_ADDR 32'hc0a80a0f
`define BAD_CALL_CODE 32'h0000007a
`define BAD_SW_ZERO 8'h00
`define BAD_SW_FULL 8'hff
`define BAD_RES_OK 8'h00
`define BAD_RES_BAD_CALL 8'h01
`define BAD_RES_NOT_RUN 8'h02
`define BAD_RES_BAD_ADDR 8'h03

// =====================================================================
// timing
`define BAD_STEP_MS 100
`define BAD_CLK_KHZ 100000
`define BAD_SUB_PER_STEP 16

`endif

/* bad_pkg.sv */
// types shared by the boot address and start-up delay block
`default_nettype none
package bad_pkg;
  // =====================================================================
  // boot sequence states, gray along sample -> delay -> run
  typedef enum logic [1:0] {
    BAD_SAMPLE = 2'b00,
    BAD_DELAY = 2'b01,
    BAD_RUN = 2'b11
  } bad_state_t;

  // =====================================================================
  // one wishbone request as seen by the slave
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } bad_wb_req_t;

  // =====================================================================
  // latched switch pair
  typedef struct packed {
    logic [3:0] hi;
    logic [3:0] lo;
  } bad_switch_t;
endpackage : bad_pkg
`default_nettype wire

/* bad_tick.sv */
// sub-step and 100 ms step pulse generator for the start-up delay
`default_nettype none
`include "bad_cfg.svh"
module bad_tick #(
  parameter int unsigned SUB_CYCLES = 625000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  output logic sub_o,
  output logic step_o
);
  localparam int unsigned CW = $clog2(SUB_CYCLES + 1);
  localparam logic [CW-1:0] SUB_LAST = CW'(SUB_CYCLES - 1);
  localparam logic [3:0] STEP_LAST = 4'(`BAD_SUB_PER_STEP - 1);

  logic [CW-1:0] cyc_q;
  logic [3:0] sub_cnt_q;
  wire sub_end = run_i && (cyc_q == SUB_LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cyc_q <= '0;
      sub_cnt_q <= 4'h0;
      sub_o <= 1'b0;
      step_o <= 1'b0;
    end else begin
      cyc_q <= sub_end ? '0 : cyc_q + CW'(1);
      sub_o <= sub_end;
      step_o <= sub_end && (sub_cnt_q == STEP_LAST);
      if (sub_end) begin
        sub_cnt_q <= sub_cnt_q + 4'h1;
      end
    end
  end
endmodule // bad_tick
`default_nettype wire

/* bad_core.sv */
// boot address composer, run-time address change and start-up delay
`default_nettype none
`include "bad_cfg.svh"
module bad_core #(
  parameter int unsigned SUB_CYCLES =
    `BAD_STEP_MS * `BAD_CLK_KHZ / `BAD_SUB_PER_STEP
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [3:0] sw_hi_i,
  input wire logic [3:0] sw_lo_i,
  output logic [31:0] net_addr_o,
  output logic addr_apply_o,
  output logic sysbus_init_o,
  output logic app_launch_o,
  output logic run_led_o,
  output logic irq_o
);
  // =====================================================================
  // helpers
  function automatic logic hit(input logic [11:0] adr, input logic [11:0] off);
    hit = (adr[11:2] == off[11:2]);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  // =====================================================================
  // bus request decode
  bad_pkg::bad_wb_req_t req;
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                 sel: wb_sel_i, dat: wb_dat_i};

  wire acc = req.cyc && req.stb && !wb_ack_o;
  wire wr = acc && req.we;
  wire wr_cfg = wr && hit(req.adr, `BAD_OFF_CFG_ADDR);
  wire wr_param = wr && hit(req.adr, `BAD_OFF_PARAM);
  wire wr_call = wr && hit(req.adr, `BAD_OFF_CALL);
  wire wr_stat = wr && hit(req.adr, `BAD_OFF_IRQ_STAT);
  wire wr_mask = wr && hit(req.adr, `BAD_OFF_IRQ_MASK);
  wire wr_dly = wr && hit(req.adr, `BAD_OFF_DELAY);

  // =====================================================================
  // state
  bad_pkg::bad_state_t state_q;
  bad_pkg::bad_switch_t sw_q;
  logic [31:0] cfg_q = `BAD_CFG_INIT;
  logic [9:0] dly_q = `BAD_DLY_INIT;
  logic [31:0] param_q;
  logic [7:0] res_q;
  logic [9:0] dly_lat_q;
  logic [9:0] step_cnt_q;
  logic [3:0] flash_cnt_q;
  logic [`BAD_IRQ_W-1:0] stat_q;
  logic [`BAD_IRQ_W-1:0] mask_q;
  logic sub_p;
  logic step_p;

  bad_tick #(
    .SUB_CYCLES(SUB_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(state_q == bad_pkg::BAD_DELAY),
    .sub_o(sub_p),
    .step_o(step_p)
  );

  // =====================================================================
  // boot address composition
  wire [7:0] sw_now = {sw_hi_i, sw_lo_i};
  wire [31:0] cfg_wr_val = merge(cfg_q, req.dat, req.sel);
  wire [31:0] boot_addr =
    (sw_now == `BAD_SW_ZERO) ? `BAD_DEF_ADDR :
    (sw_now == `BAD_SW_FULL) ? cfg_q :
    {cfg_q[31:8], sw_hi_i, sw_lo_i};

  // =====================================================================
  // address-change call and delay write checks
  wire [31:0] dly_wr_val = merge({22'h0, dly_q}, req.dat, req.sel);
  wire dly_ok = (dly_wr_val >= `BAD_DLY_MIN) && (dly_wr_val <= `BAD_DLY_MAX);
  wire call_code_ok = (req.dat == `BAD_CALL_CODE);
  wire call_run = (state_q == bad_pkg::BAD_RUN);
  wire call_addr_ok = (param_q != 32'h0);
  wire call_good = wr_call && call_code_ok && call_run && call_addr_ok;
  wire [7:0] call_res =
    !call_code_ok ? `BAD_RES_BAD_CALL :
    !call_run ? `BAD_RES_NOT_RUN :
    !call_addr_ok ? `BAD_RES_BAD_ADDR : `BAD_RES_OK;
  wire delay_end = (state_q == bad_pkg::BAD_DELAY) &&
                   (step_cnt_q == dly_lat_q);
  wire [9:0] remain = dly_lat_q - step_cnt_q;
  wire [3:0] flash_int = (remain > 10'h00f) ? 4'hf : remain[3:0];

  wire [`BAD_IRQ_W-1:0] ev;
  assign ev[`BAD_IRQ_CALL] = wr_call;
  assign ev[`BAD_IRQ_DELAY_DONE] = delay_end;
  assign ev[`BAD_IRQ_DELAY_REJ] = wr_dly && !dly_ok;

  // =====================================================================
  // read mux
  wire [31:0] rd_val =
    hit(req.adr, `BAD_OFF_CFG_ADDR) ? cfg_q :
    hit(req.adr, `BAD_OFF_SWITCH) ? {24'h0, sw_q} :
    hit(req.adr, `BAD_OFF_ACTIVE) ? net_addr_o :
    hit(req.adr, `BAD_OFF_PARAM) ? param_q :
    hit(req.adr, `BAD_OFF_RESULT) ? {24'h0, res_q} :
    hit(req.adr, `BAD_OFF_IRQ_STAT) ? {29'h0, stat_q} :
    hit(req.adr, `BAD_OFF_IRQ_MASK) ? {29'h0, mask_q} :
    hit(req.adr, `BAD_OFF_BOOT) ? {14'h0, state_q, 6'h0, step_cnt_q} :
    hit(req.adr, `BAD_OFF_DELAY) ? {22'h0, dly_q} : 32'h0;

  // =====================================================================
  // wishbone slave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= (acc && !req.we) ? rd_val : 32'h0;
    end
  end

  // =====================================================================
  // nonvolatile store and delay, not touched by reset
  always_ff @(posedge clk_i) begin
    if (wr_cfg) begin
      cfg_q <= cfg_wr_val;
    end
    if (wr_dly && dly_ok) begin
      dly_q <= dly_wr_val[9:0];
    end
  end

  // =====================================================================
  // boot sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= bad_pkg::BAD_SAMPLE;
      sw_q <= 8'h00;
      dly_lat_q <= 10'h000;
      step_cnt_q <= 10'h000;
      net_addr_o <= 32'h0;
      sysbus_init_o <= 1'b0;
      app_launch_o <= 1'b0;
    end else begin
      sysbus_init_o <= 1'b0;
      case (state_q)
        bad_pkg::BAD_SAMPLE: begin
          sw_q <= sw_now;
          net_addr_o <= boot_addr;
          dly_lat_q <= dly_q;
          step_cnt_q <= 10'h000;
          state_q <= bad_pkg::BAD_DELAY;
        end
        bad_pkg::BAD_DELAY: begin
          if (delay_end) begin
            state_q <= bad_pkg::BAD_RUN;
            sysbus_init_o <= 1'b1;
            app_launch_o <= 1'b1;
          end else if (step_p) begin
            step_cnt_q <= step_cnt_q + 10'h001;
          end
        end
        bad_pkg::BAD_RUN: begin
          if (call_good) begin
            net_addr_o <= param_q;
          end
        end
        default: state_q <= bad_pkg::BAD_SAMPLE;
      endcase
    end
  end

  // =====================================================================
  // call registers, run indicator, interrupts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      param_q <= 32'h0;
      res_q <= `BAD_RES_OK;
      addr_apply_o <= 1'b0;
      flash_cnt_q <= 4'h0;
      run_led_o <= 1'b0;
      stat_q <= '0;
      mask_q <= '0;
      irq_o <= 1'b0;
    end else begin
      if (wr_param) begin
        param_q <= merge(param_q, req.dat, req.sel);
      end
      if (wr_call) begin
        res_q <= call_res;
      end
      addr_apply_o <= call_good;
      if (state_q == bad_pkg::BAD_RUN) begin
        run_led_o <= 1'b1;
      end else if (state_q == bad_pkg::BAD_DELAY && sub_p) begin
        if (flash_cnt_q >= flash_int) begin
          flash_cnt_q <= 4'h0;
          run_led_o <= !run_led_o;
        end else begin
          flash_cnt_q <= flash_cnt_q + 4'h1;
        end
      end
      // new events win over the write-one clear
      stat_q <= (stat_q & ~(wr_stat ? req.dat[`BAD_IRQ_W-1:0] : '0)) | ev;
      if (wr_mask) begin
        mask_q <= req.dat[`BAD_IRQ_W-1:0];
      end
      irq_o <= |(stat_q & mask_q);
    end
  end

  // =====================================================================
  // checks
  property p_sw_once;
    @(posedge clk_i) disable iff (rst_i)
    (state_q != bad_pkg::BAD_SAMPLE) |=> $stable(sw_q);
  endproperty
  a_sw_once: assert property (p_sw_once)
    else $error("switch value changed after boot sample");

  property p_sw_addr;
    @(posedge clk_i) disable iff (rst_i)
    ($past(state_q) == bad_pkg::BAD_SAMPLE && state_q == bad_pkg::BAD_DELAY &&
     sw_q != `BAD_SW_ZERO && sw_q != `BAD_SW_FULL)
    |-> net_addr_o == {$past(cfg_q[31:8]), sw_q.hi, sw_q.lo};
  endproperty
  a_sw_addr: assert property (p_sw_addr)
    else $error("switch-derived address wrong");

  property p_def_addr;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == bad_pkg::BAD_DELAY && sw_q == `BAD_SW_ZERO)
    |-> net_addr_o == `BAD_DEF_ADDR;
  endproperty
  a_def_addr: assert property (p_def_addr)
    else $error("default address not used");

  property p_full_addr;
    @(posedge clk_i) disable iff (rst_i)
    ($past(state_q) == bad_pkg::BAD_SAMPLE && sw_q == `BAD_SW_FULL)
    |-> net_addr_o == $past(cfg_q);
  endproperty
  a_full_addr: assert property (p_full_addr)
    else $error("stored address not used unmodified");

  property p_launch;
    @(posedge clk_i) disable iff (rst_i)
    $rose(app_launch_o) |-> $past(step_cnt_q) == $past(dly_lat_q) &&
                            sysbus_init_o;
  endproperty
  a_launch: assert property (p_launch)
    else $error("launch before delay elapsed");

  property p_call_ok;
    @(posedge clk_i) disable iff (rst_i)
    call_good |=> res_q == `BAD_RES_OK && net_addr_o == $past(param_q) &&
                  addr_apply_o ##1 !addr_apply_o;
  endproperty
  a_call_ok: assert property (p_call_ok)
    else $error("successful call not applied");

  property p_call_err;
    @(posedge clk_i) disable iff (rst_i)
    (wr_call && !call_good) |=> res_q != `BAD_RES_OK && $stable(net_addr_o);
  endproperty
  a_call_err: assert property (p_call_err)
    else $error("failed call not reported");

  property p_call_keep;
    @(posedge clk_i) disable iff (rst_i)
    wr_call |=> $stable(cfg_q) && $stable(sw_q) && $stable(dly_q);
  endproperty
  a_call_keep: assert property (p_call_keep)
    else $error("call altered stored values");

  property p_dly_range;
    @(posedge clk_i) disable iff (rst_i)
    (wr_dly && !dly_ok) |=> $stable(dly_q) ##1 stat_q[`BAD_IRQ_DELAY_REJ];
  endproperty
  a_dly_range: assert property (p_dly_range)
    else $error("out-of-range delay accepted");

  property p_flash;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == bad_pkg::BAD_DELAY && !$past(sub_p)) |-> $stable(run_led_o);
  endproperty
  a_flash: assert property (p_flash)
    else $error("indicator toggled off a sub-step");
endmodule // bad_core
`default_nettype wire

/* boot_address_and_on_delay_tb_top.sv */
// self-checking bench for the boot address and start-up delay block
`default_nettype none
`include "bad_cfg.svh"
module boot_address_and_on_delay_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sw_hi = 4'h4;
  logic [3:0] sw_lo = 4'he;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic [31:0] net_addr;
  logic ack, apply, init, launch, led, irq;
  int fail_count = 0;
  int cmp_count = 0;
  int apply_cnt = 0;
  int cyc_cnt = 0;
  int rel = 0;
  int base;

  bad_core #(.SUB_CYCLES(4)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .sw_hi_i(sw_hi), .sw_lo_i(sw_lo),
    .net_addr_o(net_addr), .addr_apply_o(apply), .sysbus_init_o(init),
    .app_launch_o(launch), .run_led_o(led), .irq_o(irq)
  );

  always #5 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (apply === 1'b1) begin
      apply_cnt <= apply_cnt + 1;
    end
  end

  // =====================================================================
  // reporting
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // =====================================================================
  // classic wishbone single cycle
  task automatic wb_cycle(input logic w, input logic [11:0] a,
                          input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (ack === 1'b1) begin
        break;
      end
    end
    if (n == 20) begin
      fail_count++;
      close_out();
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wb_wr(input logic [11:0] a, input logic [31:0] d);
    wb_cycle(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    wb_cycle(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // =====================================================================
  // boot with a switch pair: hold reset for 16 cycles, then release it and note the cycle
  task automatic boot(input logic [3:0] hi, input logic [3:0] lo);
    @(posedge clk_i);
    rst_i <= 1'b1;
    sw_hi <= hi;
    sw_lo <= lo;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rel = cyc_cnt;
  endtask

  task automatic wait_launch(input int dly);
    int n, tg, g, first_gap, last_gap;
    logic last;
    tg = 0;
    g = 0;
    first_gap = 0;
    last_gap = 0;
    last = led;
    for (n = 0; n < 4000 && init !== 1'b1; n++) begin
      @(posedge clk_i);
      g++;
      if (led !== last) begin
        tg++;
        if (tg == 2) begin
          first_gap = g;
        end
        last_gap = g;
        g = 0;
      end
      last = led;
    end
    if (n == 4000) begin
      fail_count++;
      close_out();
    end
    n = cyc_cnt - rel;
    // step timing, launch wait
    chk(32'(n >= dly * 64 && n <= dly * 64 + 8), 32'h1);
    // flash gets faster
    chk(32'(tg >= 10 && last_gap < first_gap), 32'h1);
    repeat (3) @(posedge clk_i);
    chk(32'(launch), 32'h1);
  endtask

  // =====================================================================
  // main sequence
  initial begin
    boot(4'h4, 4'he);
    rd_chk(`BAD_OFF_CFG_ADDR, `BAD_CFG_INIT);
    rd_chk(`BAD_OFF_SWITCH, 32'h0000004e);
    sw_hi <= 4'h1;
    sw_lo <= 4'h2;
    rd_chk(`BAD_OFF_ACTIVE, 32'hc0a80a4e);
    chk(net_addr, 32'hc0a80a4e);
    rd_chk(`BAD_OFF_SWITCH, 32'h0000004e);
    chk(32'(launch), 32'h0);
    wb_wr(`BAD_OFF_CALL, `BAD_CALL_CODE);
    rd_chk(`BAD_OFF_RESULT, 32'h00000002);
    wb_wr(12'h100, 32'hffffffff);
    rd_chk(12'h100, 32'h0);
    wait_launch(10);
    chk(32'(init), 32'h0);
    chk(32'(led), 32'h1);
    rd_chk(`BAD_OFF_BOOT, 32'h0003000a);
    // interrupt raise, mask, clear
    rd_chk(`BAD_OFF_IRQ_STAT, 32'h00000003);
    wb_wr(`BAD_OFF_IRQ_MASK, 32'h0);
    repeat (3) @(posedge clk_i);
    chk(32'(irq), 32'h0);
    wb_wr(`BAD_OFF_IRQ_MASK, 32'h00000002);
    repeat (3) @(posedge clk_i);
    chk(32'(irq), 32'h1);
    wb_wr(`BAD_OFF_IRQ_STAT, 32'h00000003);
    repeat (3) @(posedge clk_i);
    chk(32'(irq), 32'h0);
    rd_chk(`BAD_OFF_IRQ_STAT, 32'h0);
    // delay range edges
    rd_chk(`BAD_OFF_DELAY, 32'h0000000a);
    wb_wr(`BAD_OFF_DELAY, 32'h00000009);
    rd_chk(`BAD_OFF_DELAY, 32'h0000000a);
    rd_chk(`BAD_OFF_IRQ_STAT, 32'h00000004);
    wb_wr(`BAD_OFF_DELAY, 32'h00000259);
    rd_chk(`BAD_OFF_DELAY, 32'h0000000a);
    wb_wr(`BAD_OFF_DELAY, 32'h00000258);
    rd_chk(`BAD_OFF_DELAY, 32'h00000258);
    wb_wr(`BAD_OFF_DELAY, 32'h00000014);
    // run-time address change
    wb_wr(`BAD_OFF_PARAM, 32'h0a000001);
    base = apply_cnt;
    wb_wr(`BAD_OFF_CALL, `BAD_CALL_CODE);
    rd_chk(`BAD_OFF_RESULT, 32'h0);
    rd_chk(`BAD_OFF_ACTIVE, 32'h0a000001);
    chk(net_addr, 32'h0a000001);
    chk(32'(apply_cnt - base), 32'h1);
    wb_wr(`BAD_OFF_CALL, 32'h0000007b);
    rd_chk(`BAD_OFF_RESULT, 32'h00000001);
    wb_wr(`BAD_OFF_PARAM, 32'h0);
    wb_wr(`BAD_OFF_CALL, `BAD_CALL_CODE);
    rd_chk(`BAD_OFF_RESULT, 32'h00000003);
    rd_chk(`BAD_OFF_ACTIVE, 32'h0a000001);
    chk(32'(apply_cnt - base), 32'h1);
    rd_chk(`BAD_OFF_CFG_ADDR, `BAD_CFG_INIT);
    rd_chk(`BAD_OFF_SWITCH, 32'h0000004e);
    wb_wr(`BAD_OFF_CFG_ADDR, 32'h11223344);
    sel <= 4'h1;
    wb_wr(`BAD_OFF_CFG_ADDR, 32'h556677aa);
    sel <= 4'hf;
    rd_chk(`BAD_OFF_CFG_ADDR, 32'h112233aa);
    // reboots with the special switch settings and one ordinary pair
    boot(4'h0, 4'h0);
    rd_chk(`BAD_OFF_ACTIVE, 32'hc0a80a0f);
    rd_chk(`BAD_OFF_DELAY, 32'h00000014);
    wait_launch(20);
    boot(4'hf, 4'hf);
    rd_chk(`BAD_OFF_ACTIVE, 32'h112233aa);
    boot(4'h7, 4'h3);
    rd_chk(`BAD_OFF_ACTIVE, 32'h11223373);
    close_out();
  end
endmodule // boot_address_and_on_delay_tb_top
`default_nettype wire
